// *** design/ctfd_pkg.sv ***
package ctfd_pkg;
   // ******************************************
   // Configuration register offsets
   // ******************************************
   localparam logic [10:0] CTFD_OPTION_OFS = 11'h0_200;
   localparam logic [10:0] CTFD_PINREP_OFS = 11'h0_204;
   localparam logic [10:0] CTFD_COPY_OFS = 11'h0_206;
   localparam logic [7:0] CTFD_PINREP_RESET = 8'h0_c;
   localparam logic [7:0] CTFD_COPY_RESET = 8'h0_0;
   localparam logic CTFD_MASK_RESET = 1'b1;
   localparam logic [5:0] CTFD_INDEX_RESET = 6'h0_0;
   localparam int CTFD_CHG_BIT = 5;
   localparam int CTFD_RAW_BIT = 1;
   localparam int CTFD_COPY_BIT = 4;
   localparam logic [5:0] CTFD_PRI_BASE = 6'h1_f;
   localparam logic [5:0] CTFD_PRI_ALT = 6'h3_f;
   localparam logic [7:0] CTFD_DRIVE_ADDR_IDLE = 8'h0_0;
   // ******************************************
   // Task file slot indices
   // ******************************************
   localparam logic [3:0] CTFD_SLOT_DATA = 4'h0;
   localparam logic [3:0] CTFD_SLOT_ERR = 4'h1;
   localparam logic [3:0] CTFD_SLOT_STAT = 4'h7;
   localparam logic [3:0] CTFD_SLOT_EVEN = 4'h8;
   localparam logic [3:0] CTFD_SLOT_ODD = 4'h9;
   localparam logic [3:0] CTFD_SLOT_DERR = 4'hd;
   localparam logic [3:0] CTFD_SLOT_ALT = 4'he;
   localparam logic [3:0] CTFD_SLOT_DADDR = 4'hf;
   typedef enum logic [1:0] {
      CTFD_MAP_MEM = 2'b00,
      CTFD_MAP_CONTIG = 2'b01,
      CTFD_MAP_PRIMARY = 2'b10,
      CTFD_MAP_SECONDARY = 2'b11
   } ctfd_map_type;
endpackage

// *** design/ctfd_sync.sv ***
`timescale 1ns/1ps
module ctfd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   // ******************************************
   // Two flop synchroniser
   // ******************************************
   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// *** design/ctfd_taskfile.sv ***
`timescale 1ns/1ps
module ctfd_taskfile (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [2:0] wr_slot,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_slot,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:7];
   // ******************************************
   // Eight byte task file store
   // ******************************************
   // Write port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_slot] <= wr_data;
      end
   end
   // Registered read port
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_slot];
      end
   end
endmodule

// *** design/ctfd_top.sv ***
`timescale 1ns/1ps
module ctfd_top
   import ctfd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic reg_n,
   input wire logic [10:0] addr,
   input wire logic [15:0] wdata,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic iord_n,
   input wire logic iowr_n,
   input wire logic fixed_disk_mode,
   input wire logic ready_pin,
   input wire logic [7:0] status_in,
   input wire logic [7:0] error_in,
   output logic [15:0] rdata,
   output logic rdata_valid,
   output logic [15:0] data_word,
   output logic data_word_strobe,
   output logic [7:0] feature_out,
   output logic [7:0] command_out,
   output logic command_strobe,
   output logic [7:0] device_control_out,
   output logic [5:0] map_index,
   output logic copy_number
);
   // ******************************************
   // Input synchronisers
   // ******************************************
   logic [10:0] addr_s;
   logic [15:0] wdata_s;
   logic [6:0] ctl_s;
   logic [6:0] ctl_raw;
   logic reg_s, oe_s, we_s, iord_s, iowr_s, fdm_s, rdy_s;
   assign ctl_raw = {reg_n, oe_n, we_n, iord_n, iowr_n,
                     fixed_disk_mode, ready_pin};
   ctfd_sync #(.WIDTH(11)) sync_addr (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(addr),
      .sync_out(addr_s)
   );
   ctfd_sync #(.WIDTH(16)) sync_data (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(wdata),
      .sync_out(wdata_s)
   );
   ctfd_sync #(.WIDTH(7)) sync_ctl (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(ctl_raw),
      .sync_out(ctl_s)
   );
   assign {reg_s, oe_s, we_s, iord_s, iowr_s, fdm_s, rdy_s} = ctl_s;

   // ******************************************
   // Strobe edge detection
   // ******************************************
   logic oe_d, we_d, iord_d, iowr_d;
   logic rd_mem, wr_mem, rd_io, wr_io;
   // Delayed strobes; reset low like the synchroniser, so no false edge
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         oe_d <= 1'b0;
         we_d <= 1'b0;
         iord_d <= 1'b0;
         iowr_d <= 1'b0;
      end else begin
         oe_d <= oe_s;
         we_d <= we_s;
         iord_d <= iord_s;
         iowr_d <= iowr_s;
      end
   end
   assign rd_mem = oe_d & ~oe_s;
   assign wr_mem = we_d & ~we_s;
   assign rd_io = iord_d & ~iord_s;
   assign wr_io = iowr_d & ~iowr_s;

   // ******************************************
   // Configuration registers
   // ******************************************
   logic [5:0] index_q;
   logic copy_q;
   logic chg_q;
   logic mask_q;
   logic rdy_d;
   logic cfg_ok;
   logic cfg_wr, cfg_rd;
   // Attribute space usable only outside fixed-disk mode
   assign cfg_ok = ~reg_s & ~fdm_s;
   assign cfg_wr = cfg_ok & wr_mem;
   assign cfg_rd = cfg_ok & rd_mem;

   // Mapping index, reset to memory mapped
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         index_q <= CTFD_INDEX_RESET;
      end else if (cfg_wr && addr_s == CTFD_OPTION_OFS) begin
         index_q <= wdata_s[5:0];
      end
   end

   // Copy number field, other bits read zero
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         copy_q <= CTFD_COPY_RESET[CTFD_COPY_BIT];
      end else if (cfg_wr && addr_s == CTFD_COPY_OFS) begin
         copy_q <= wdata_s[CTFD_COPY_BIT];
      end
   end

   // Ready pin history for change detection
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rdy_d <= 1'b0;
      end else begin
         rdy_d <= rdy_s;
      end
   end

   // Ready mask written through the raw bit position
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mask_q <= CTFD_MASK_RESET;
      end else if (cfg_wr && addr_s == CTFD_PINREP_OFS) begin
         mask_q <= wdata_s[CTFD_RAW_BIT];
      end
   end

   // Sticky change flag; a change beats a host write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         chg_q <= CTFD_PINREP_RESET[CTFD_CHG_BIT];
      end else if ((rdy_s != rdy_d) && mask_q) begin
         chg_q <= 1'b1;
      end else if (cfg_wr && addr_s == CTFD_PINREP_OFS) begin
         chg_q <= wdata_s[CTFD_CHG_BIT];
      end
   end

   // ******************************************
   // Task file address decode
   // ******************************************
   logic tf_hit;
   logic [3:0] slot;
   logic tf_rd, tf_wr;
   // Decode per mapping mode
   always_comb begin
      tf_hit = 1'b0;
      slot = 4'h0;
      tf_rd = 1'b0;
      tf_wr = 1'b0;
      case (ctfd_map_type'(index_q[1:0]))
         CTFD_MAP_MEM: begin
            tf_hit = reg_s & (index_q[5:2] == 4'h0);
            tf_rd = rd_mem;
            tf_wr = wr_mem;
            if (addr_s[10]) begin
               slot = addr_s[0] ? CTFD_SLOT_ODD : CTFD_SLOT_EVEN;
            end else begin
               tf_hit = tf_hit & (addr_s[9:4] == 6'h00);
               slot = addr_s[3:0];
            end
         end
         CTFD_MAP_CONTIG: begin
            tf_hit = ~reg_s & (index_q[5:2] == 4'h0);
            slot = addr_s[3:0];
            tf_rd = rd_io;
            tf_wr = wr_io;
         end
         CTFD_MAP_PRIMARY: begin
            tf_rd = rd_io;
            tf_wr = wr_io;
            if (addr_s[9:4] == CTFD_PRI_BASE && !addr_s[3]) begin
               tf_hit = ~reg_s & (index_q[5:2] == 4'h0);
               slot = {1'b0, addr_s[2:0]};
            end else if (addr_s[9:4] == CTFD_PRI_ALT &&
                         addr_s[3:1] == 3'b011) begin
               tf_hit = ~reg_s & (index_q[5:2] == 4'h0);
               slot = {3'b111, addr_s[0]};
            end
         end
         default: begin
            tf_hit = 1'b0; // secondary map not carried
         end
      endcase
   end

   // ******************************************
   // Task file storage and side registers
   // ******************************************
   logic st_wr;
   logic [2:0] st_slot;
   logic [7:0] st_rd;
   logic [7:0] odd_byte;
   logic odd_wr;
   // Byte slots 2..6 and even data byte share the store
   assign st_slot = (slot == CTFD_SLOT_EVEN) ? 3'd0 : slot[2:0];
   assign st_wr = tf_hit & tf_wr & ((slot[3] == 1'b0 &&
                  slot != CTFD_SLOT_ERR && slot != CTFD_SLOT_STAT) ||
                  slot == CTFD_SLOT_EVEN);
   assign odd_wr = tf_hit & tf_wr & (slot == CTFD_SLOT_ODD);

   ctfd_taskfile u_store (
      .core_clk(core_clk),
      .rstn(rstn),
      .wr_en(st_wr),
      .wr_slot(st_slot),
      .wr_data(wdata_s[7:0]),
      .rd_slot(st_slot),
      .rd_data(st_rd)
   );

   // Odd data byte, upper half of word at slot 0
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         odd_byte <= 8'h00;
      end else if (odd_wr) begin
         odd_byte <= wdata_s[7:0];
      end else if (tf_hit && tf_wr && slot == CTFD_SLOT_DATA) begin
         odd_byte <= wdata_s[15:8];
      end
   end

   // Word strobe on data port write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         data_word <= 16'h0000;
         data_word_strobe <= 1'b0;
      end else begin
         data_word_strobe <= tf_hit & tf_wr &
                             (slot == CTFD_SLOT_DATA);
         if (tf_hit && tf_wr && slot == CTFD_SLOT_DATA) begin
            data_word <= wdata_s;
         end
      end
   end

   // Write-only halves of paired locations
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         feature_out <= 8'h00;
         command_out <= 8'h00;
         command_strobe <= 1'b0;
         device_control_out <= 8'h00;
      end else begin
         command_strobe <= tf_hit & tf_wr & (slot == CTFD_SLOT_STAT);
         if (tf_hit && tf_wr && (slot == CTFD_SLOT_ERR ||
             slot == CTFD_SLOT_DERR)) begin
            feature_out <= wdata_s[7:0];
         end
         if (tf_hit && tf_wr && slot == CTFD_SLOT_STAT) begin
            command_out <= wdata_s[7:0];
         end
         if (tf_hit && tf_wr && slot == CTFD_SLOT_ALT) begin
            device_control_out <= wdata_s[7:0];
         end
         // Reserved drive address location: no write effect
      end
   end

   // ******************************************
   // Read data path
   // ******************************************
   logic rd_pend;
   logic [3:0] rd_slot_q;
   logic [10:0] rd_addr_q;
   logic rd_cfg_q;
   logic [15:0] next_rdata;
   // Capture read request; store data lands next cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_pend <= 1'b0;
         rd_slot_q <= 4'h0;
         rd_addr_q <= 11'h000;
         rd_cfg_q <= 1'b0;
      end else begin
         rd_pend <= (tf_hit & tf_rd) | cfg_rd;
         rd_slot_q <= slot;
         rd_addr_q <= addr_s;
         rd_cfg_q <= cfg_rd;
      end
   end

   // Select read source
   always_comb begin
      next_rdata = 16'h0000;
      if (rd_cfg_q) begin
         case (rd_addr_q)
            CTFD_OPTION_OFS: next_rdata = {10'h000, index_q};
            CTFD_PINREP_OFS: begin
               next_rdata = {8'h00, CTFD_PINREP_RESET};
               next_rdata[CTFD_CHG_BIT] = chg_q;
               next_rdata[CTFD_RAW_BIT] = rdy_s;
            end
            CTFD_COPY_OFS: next_rdata[CTFD_COPY_BIT] = copy_q;
            default: next_rdata = 16'h0000;
         endcase
      end else begin
         case (rd_slot_q)
            CTFD_SLOT_DATA: next_rdata = {odd_byte, st_rd};
            CTFD_SLOT_ERR, CTFD_SLOT_DERR:
               next_rdata = {8'h00, error_in};
            CTFD_SLOT_STAT, CTFD_SLOT_ALT:
               next_rdata = {8'h00, status_in};
            CTFD_SLOT_ODD: next_rdata = {8'h00, odd_byte};
            CTFD_SLOT_DADDR:
               next_rdata = {8'h00, CTFD_DRIVE_ADDR_IDLE};
            default: next_rdata = {8'h00, st_rd};
         endcase
      end
   end

   // Registered read answer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rdata <= 16'h0000;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= rd_pend;
         if (rd_pend) begin
            rdata <= next_rdata;
         end
      end
   end

   // Configuration outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         map_index <= CTFD_INDEX_RESET;
         copy_number <= 1'b0;
      end else begin
         map_index <= index_q;
         copy_number <= copy_q;
      end
   end

   // ******************************************
   // Assertions
   // ******************************************
   chg_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (rdy_s != rdy_d) && mask_q |=> chg_q)
      else $error("ready change did not set flag");
   chg_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cfg_wr && addr_s == CTFD_PINREP_OFS && rdy_s == rdy_d |=>
      chg_q == $past(wdata_s[CTFD_CHG_BIT]))
      else $error("flag write not taken");
   raw_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rd_cfg_q && rd_addr_q == CTFD_PINREP_OFS |=>
      rdata[CTFD_RAW_BIT] == $past(rdy_s))
      else $error("raw ready read wrong");
   mask_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !mask_q && !chg_q && !cfg_wr |=> !chg_q)
      else $error("masked flag got set");
   copy_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rd_cfg_q && rd_addr_q == CTFD_COPY_OFS |=>
      rdata == {11'h000, copy_q, 4'h0})
      else $error("copy register read wrong");
   fixed_disk_a: assert property (@(posedge core_clk)
      disable iff (!rstn)
      fdm_s |=> $stable(copy_q) && $stable(index_q) && $stable(mask_q))
      else $error("config changed in fixed disk");
   cmd_split_a: assert property (@(posedge core_clk) disable iff (!rstn)
      tf_hit && tf_wr && slot == CTFD_SLOT_STAT |=>
      command_strobe ##1 !command_strobe)
      else $error("command strobe wrong");
   index_reset_a: assert property (@(posedge core_clk)
      !rstn |=> index_q == CTFD_INDEX_RESET)
      else $error("index not reset");
   read_lat_a: assert property (@(posedge core_clk) disable iff (!rstn)
      tf_hit && tf_rd |-> ##2 rdata_valid)
      else $error("read answer late");
   cov_cfg_c: cover property (@(posedge core_clk) cfg_wr);
   cov_mem_c: cover property (@(posedge core_clk) tf_hit && wr_mem);
   cov_io_c: cover property (@(posedge core_clk) tf_hit && rd_io);
   cov_chg_c: cover property (@(posedge core_clk) !chg_q ##1 chg_q);
endmodule

// *** verification/card_task_file_decoder_test.sv ***
`timescale 1ns/1ps
// ****************************************
// Testbench for the task file decoder
// ****************************************
module card_task_file_decoder_test
   import ctfd_pkg::*;
;
   logic core_clk;
   logic rstn;
   logic reg_n;
   logic [10:0] addr;
   logic [15:0] wdata;
   logic oe_n;
   logic we_n;
   logic iord_n;
   logic iowr_n;
   logic fixed_disk_mode;
   logic ready_pin;
   logic [7:0] status_in;
   logic [7:0] error_in;
   logic [15:0] rdata;
   logic rdata_valid;
   logic [15:0] data_word;
   logic data_word_strobe;
   logic [7:0] feature_out;
   logic [7:0] command_out;
   logic command_strobe;
   logic [7:0] device_control_out;
   logic [5:0] map_index;
   logic copy_number;
   logic [15:0] got;
   int bad_count = 0;
   int checks_done = 0;
   int cmd_pulses = 0;
   int word_pulses = 0;

   ctfd_top ctfd_top_inst (
      .core_clk(core_clk), .rstn(rstn), .reg_n(reg_n), .addr(addr),
      .wdata(wdata), .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n),
      .iowr_n(iowr_n), .fixed_disk_mode(fixed_disk_mode),
      .ready_pin(ready_pin), .status_in(status_in), .error_in(error_in),
      .rdata(rdata), .rdata_valid(rdata_valid), .data_word(data_word),
      .data_word_strobe(data_word_strobe), .feature_out(feature_out),
      .command_out(command_out), .command_strobe(command_strobe),
      .device_control_out(device_control_out), .map_index(map_index),
      .copy_number(copy_number)
   );

   ctfd_host_model ctfd_host_model_inst (
      .core_clk(core_clk), .rdata(rdata), .rdata_valid(rdata_valid),
      .reg_n(reg_n), .addr(addr), .wdata(wdata), .oe_n(oe_n),
      .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n)
   );

   // Clock at 50 MHz
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Count command and data word pulses
   always @(posedge core_clk) begin
      if (command_strobe === 1'b1) begin
         cmd_pulses <= cmd_pulses + 1;
      end
      if (data_word_strobe === 1'b1) begin
         word_pulses <= word_pulses + 1;
      end
   end

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic wr(input logic io, input logic rg, input logic [10:0] a,
      input logic [15:0] d);
      logic [15:0] q;
      ctfd_host_model_inst.access(io, 1'b1, rg, a, d, q);
   endtask

   task automatic rd(input logic io, input logic rg, input logic [10:0] a);
      ctfd_host_model_inst.access(io, 1'b0, rg, a, 16'h0000, got);
   endtask

   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] act);
      checks_done++;
      if (act !== exp) begin
         bad_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask

   task automatic chk_word(input logic [15:0] exp, input logic [15:0] act);
      checks_done++;
      if (act !== exp) begin
         bad_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask

   task automatic finish_test;
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic pin_to(input logic v);
      ready_pin <= v;
      repeat (6) @(posedge core_clk);
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      finish_test;
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      fixed_disk_mode = 1'b0;
      ready_pin = 1'b0;
      status_in = 8'ha5;
      error_in = 8'h3c;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      // Reset values
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h0c, got[7:0]);
      rd(0, 0, CTFD_COPY_OFS);
      chk_byte(8'h00, got[7:0]);
      chk_byte(8'h00, {2'b00, map_index});
      // Ready change flag, host write and mask
      pin_to(1'b1);
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h2e, got[7:0]);
      wr(0, 0, CTFD_PINREP_OFS, 16'h0000);
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h0e, got[7:0]);
      wr(0, 0, CTFD_PINREP_OFS, 16'h0020);
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h2e, got[7:0]);
      wr(0, 0, CTFD_PINREP_OFS, 16'h0000);
      pin_to(1'b0);
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h0c, got[7:0]);
      wr(0, 0, CTFD_PINREP_OFS, 16'h0002);
      pin_to(1'b1);
      rd(0, 0, CTFD_PINREP_OFS);
      chk_byte(8'h2e, got[7:0]);
      // Copy register, and fixed-disk lockout
      wr(0, 0, CTFD_COPY_OFS, 16'h00ff);
      rd(0, 0, CTFD_COPY_OFS);
      chk_byte(8'h10, got[7:0]);
      chk_byte(8'h01, {7'h00, copy_number});
      fixed_disk_mode <= 1'b1;
      wr(0, 0, CTFD_COPY_OFS, 16'h0000);
      // A refused read gets no answer, so got keeps its marker
      rd(0, 0, CTFD_COPY_OFS);
      chk_word(16'hffff, got);
      fixed_disk_mode <= 1'b0;
      rd(0, 0, CTFD_COPY_OFS);
      chk_byte(8'h10, got[7:0]);
      wr(0, 0, CTFD_COPY_OFS, 16'h0000);
      wr(0, 0, CTFD_OPTION_OFS, 16'h0000);
      // Memory map, base registers
      for (int i = 2; i < 7; i++) begin
         wr(0, 1, 11'(i), 16'(8'h30 + i));
      end
      for (int i = 2; i < 7; i++) begin
         rd(0, 1, 11'(i));
         chk_byte(8'(8'h30 + i), got[7:0]);
      end
      // Paired locations and aliases
      wr(0, 1, 11'h001, 16'h0011);
      chk_byte(8'h11, feature_out);
      rd(0, 1, 11'h001);
      chk_byte(8'h3c, got[7:0]);
      wr(0, 1, 11'h00d, 16'h0022);
      chk_byte(8'h22, feature_out);
      rd(0, 1, 11'h00d);
      chk_byte(8'h3c, got[7:0]);
      wr(0, 1, 11'h007, 16'h0033);
      chk_byte(8'h33, command_out);
      rd(0, 1, 11'h007);
      chk_byte(8'ha5, got[7:0]);
      wr(0, 1, 11'h00e, 16'h0044);
      chk_byte(8'h44, device_control_out);
      rd(0, 1, 11'h00e);
      chk_byte(8'ha5, got[7:0]);
      wr(0, 1, 11'h00f, 16'h0055);
      chk_word(16'h2233, {feature_out, command_out});
      chk_byte(8'h44, device_control_out);
      chk_byte(8'h01, 8'(cmd_pulses));
      rd(0, 1, 11'h00f);
      chk_byte(8'h00, got[7:0]);
      // Data word, byte aliases, A10 window
      wr(0, 1, 11'h000, 16'hbeef);
      chk_word(16'hbeef, data_word);
      chk_byte(8'h01, 8'(word_pulses));
      rd(0, 1, 11'h000);
      chk_word(16'hbeef, got);
      rd(0, 1, 11'h008);
      chk_byte(8'hef, got[7:0]);
      rd(0, 1, 11'h009);
      chk_byte(8'hbe, got[7:0]);
      rd(0, 1, 11'h5fe);
      chk_byte(8'hef, got[7:0]);
      rd(0, 1, 11'h6ab);
      chk_byte(8'hbe, got[7:0]);
      wr(0, 1, 11'h7fd, 16'h005a);
      rd(0, 1, 11'h009);
      chk_byte(8'h5a, got[7:0]);
      // Memory map with A10 low and A9..A4 not zero decodes nothing
      rd(0, 1, 11'h012);
      chk_word(16'hffff, got);
      // Contiguous I/O map
      wr(0, 0, CTFD_OPTION_OFS, 16'h0001);
      chk_byte(8'h01, {2'b00, map_index});
      wr(1, 0, 11'h7f2, 16'h0066);
      rd(1, 0, 11'h012);
      chk_byte(8'h66, got[7:0]);
      rd(0, 1, 11'h002);
      chk_word(16'hffff, got);
      // Primary I/O map
      wr(0, 0, CTFD_OPTION_OFS, 16'h0002);
      rd(0, 0, CTFD_OPTION_OFS);
      chk_byte(8'h02, got[7:0]);
      wr(1, 0, 11'h1f3, 16'h0077);
      rd(1, 0, 11'h1f3);
      chk_byte(8'h77, got[7:0]);
      wr(1, 0, 11'h3f6, 16'h0088);
      chk_byte(8'h88, device_control_out);
      rd(1, 0, 11'h3f7);
      chk_byte(8'h00, got[7:0]);
      rd(1, 0, 11'h0f3);
      chk_word(16'hffff, got);
      // Secondary code selects no primary decode
      wr(0, 0, CTFD_OPTION_OFS, 16'h0003);
      chk_byte(8'h03, {2'b00, map_index});
      rd(1, 0, 11'h1f3);
      chk_word(16'hffff, got);
      // Index with upper bits set decodes nothing
      wr(0, 0, CTFD_OPTION_OFS, 16'h0004);
      rd(0, 1, 11'h002);
      chk_word(16'hffff, got);
      // Second reset restores the index and copy register
      wr(0, 0, CTFD_COPY_OFS, 16'h0010);
      chk_byte(8'h01, {7'h00, copy_number});
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk_byte(8'h00, {2'b00, map_index});
      rd(0, 0, CTFD_COPY_OFS);
      chk_byte(8'h00, got[7:0]);
      finish_test;
   end
endmodule

// *** verification/ctfd_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host bus controller model
// ****************************************
module ctfd_host_model (
   input wire logic core_clk,
   input wire logic [15:0] rdata,
   input wire logic rdata_valid,
   output logic reg_n,
   output logic [10:0] addr,
   output logic [15:0] wdata,
   output logic oe_n,
   output logic we_n,
   output logic iord_n,
   output logic iowr_n
);
   // Idle bus at time zero
   initial begin
      reg_n = 1'b1;
      addr = 11'h000;
      wdata = 16'h0000;
      oe_n = 1'b1;
      we_n = 1'b1;
      iord_n = 1'b1;
      iowr_n = 1'b1;
   end

   // One access: setup, strobe until taken, then release
   task automatic access(input logic io, input logic wr, input logic rg,
      input logic [10:0] a, input logic [15:0] d, output logic [15:0] q);
      logic got;
      got = 1'b0;
      q = 16'hffff;
      @(posedge core_clk);
      reg_n <= rg;
      addr <= a;
      wdata <= d;
      repeat (3) @(posedge core_clk);
      // Memory strobes for memory cycles, I/O strobes otherwise
      oe_n <= io | wr;
      we_n <= io | ~wr;
      iord_n <= ~io | wr;
      iowr_n <= ~io | ~wr;
      if (wr) begin
         repeat (6) @(posedge core_clk);
      end else begin
         for (int n = 0; n < 12 && !got; n++) begin
            @(posedge core_clk);
            if (rdata_valid === 1'b1) begin
               q = rdata;
               got = 1'b1;
            end
         end
      end
      oe_n <= 1'b1;
      we_n <= 1'b1;
      iord_n <= 1'b1;
      iowr_n <= 1'b1;
      // Released data lines no longer hold the last value
      wdata <= ~d;
      repeat (3) @(posedge core_clk);
   endtask
endmodule
